// ---- design/fault_monitor_pkg.sv ----
package fault_monitor_pkg;

  localparam int CLK_KHZ          = 250000;
  localparam int HOST_TIMEOUT_MS  = 2000;
  localparam int PANEL_START_MS   = 5000;
  localparam int PANEL_LOSS_MS    = 2000;
  localparam int TICK_MS          = 1;
  localparam int HOST_TIMEOUT_CYC = HOST_TIMEOUT_MS * CLK_KHZ;
  localparam int PANEL_START_CYC  = PANEL_START_MS * CLK_KHZ;
  localparam int PANEL_LOSS_CYC   = PANEL_LOSS_MS * CLK_KHZ;
  localparam int MS_CYC           = TICK_MS * CLK_KHZ;

  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_ANS_DLY  = 8'h04;
  localparam logic [7:0] ADDR_NOLOAD   = 8'h08;
  localparam logic [7:0] ADDR_CLEAR    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;

  localparam logic [1:0]  RUN_SRC_PANEL   = 2'h0;
  localparam logic [1:0]  ACTION_MAX      = 2'h2;
  localparam logic [15:0] ANS_DLY_RESET   = 16'h0064;
  localparam logic [15:0] NOLOAD_RESET    = 16'h0000;
  localparam int          NFAULT          = 13;
  localparam int          NTERM           = 5;
  localparam int          STATUS_FLAG_LSB = 16;
  // panel present bit idles high, so no false removal after reset
  localparam logic [6:0]  SYNC_RESET      = 7'h20;

  localparam int F_EXT    = 0;
  localparam int F_DISC   = 5;
  localparam int F_HOST   = 6;
  localparam int F_OPT    = 7;
  localparam int F_ANS    = 8;
  localparam int F_BRAKE  = 9;
  localparam int F_RUN    = 10;
  localparam int F_PSTART = 11;
  localparam int F_PLOSS  = 12;

  // code = fault index + 1, zero means no fault
  typedef enum logic [3:0] {
    CODE_NONE                = 4'h0,
    EXT_FAULT_CODE_THIRD     = 4'h1,
    EXT_FAULT_CODE_FOURTH    = 4'h2,
    EXT_FAULT_CODE_FIFTH     = 4'h3,
    EXT_FAULT_CODE_SIXTH     = 4'h4,
    EXT_FAULT_CODE_SEVENTH   = 4'h5,
    OPERATOR_DISCONNECT_FAULT = 4'h6,
    HOST_LINK_FAULT          = 4'h7,
    OPTION_LINK_FAULT        = 4'h8,
    CONTACTOR_ANSWER_FAULT   = 4'h9,
    BRAKE_OPEN_CURRENT_FAULT = 4'hA,
    RUNNING_CURRENT_FAULT    = 4'hB,
    PANEL_LINK_START_FAULT   = 4'hC,
    PANEL_LINK_LOSS_FAULT    = 4'hD
  } fault_code_type;

  typedef enum logic [2:0] {
    PANEL_WAIT = 3'h1,
    PANEL_UP   = 3'h2,
    PANEL_DEAD = 3'h4
  } panel_state_type;

  typedef struct packed {
    logic       host_link_timeout_enable;
    logic [1:0] host_link_error_action;
    logic [1:0] run_command_source_sel;
  } settings_type;

  localparam int          SET_W     = 5;
  localparam logic [4:0]  SET_RESET = 5'h00;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

endpackage

// ---- design/drive_fault_monitor.sv ----
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Function
// - each terminal fault gets its own code
// - panel removed with panel run source
// - host link silent two seconds when enabled with error action at most 2
// - option link loss only after established
// - contactor answer missing past set delay
// - low current when brake opens
// - low current while running
// - panel link not up within five seconds
// - panel link silent two seconds after up
module drive_fault_monitor #(
  parameter int HOST_TIMEOUT_CYC = fault_monitor_pkg::HOST_TIMEOUT_CYC,
  parameter int PANEL_START_CYC  = fault_monitor_pkg::PANEL_START_CYC,
  parameter int PANEL_LOSS_CYC   = fault_monitor_pkg::PANEL_LOSS_CYC,
  parameter int MS_CYC           = fault_monitor_pkg::MS_CYC
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  input  wire fault_monitor_pkg::bus_req_type i_bus,
  output logic [31:0]              o_rdata,
  input  wire logic [4:0]          i_ext_fault_pin,
  input  wire logic                i_panel_present_pin,
  input  wire logic                i_contactor_answer_pin,
  input  wire logic                i_panel_rx_ok,
  input  wire logic                i_host_rx_ok,
  input  wire logic                i_option_link_up,
  input  wire logic                i_contactor_close,
  input  wire logic                i_brake_open,
  input  wire logic                i_running,
  input  wire logic [15:0]         i_out_current,
  output logic [3:0]               o_fault_code,
  output logic                     o_fault_active
);

  localparam int NPIN = fault_monitor_pkg::NTERM + 2;

  logic [NPIN-1:0]      sync1_r;
  logic [NPIN-1:0]      sync2_r;
  logic [4:0]           ext_s;
  logic                 present_s;
  logic                 answer_s;
  fault_monitor_pkg::settings_type set_r;
  logic [15:0]          ans_dly_r;
  logic [15:0]          noload_r;
  logic                 clear;
  logic [fault_monitor_pkg::NFAULT-1:0] raw;
  logic [fault_monitor_pkg::NFAULT-1:0] flags_r;
  logic [3:0]           code_r;
  logic [3:0]           raw_code;
  logic [31:0]          host_cnt_r;
  logic                 host_on;
  logic                 opt_est_r;
  logic [31:0]          ms_cnt_r;
  logic                 ms_tick;
  logic [15:0]          ans_cnt_r;
  logic                 low_cur;
  fault_monitor_pkg::panel_state_type panel_r;
  logic [31:0]          panel_cnt_r;

  // pin inputs pass two flops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_r <= fault_monitor_pkg::SYNC_RESET;
      sync2_r <= fault_monitor_pkg::SYNC_RESET;
    end else begin
      sync1_r <= {i_contactor_answer_pin, i_panel_present_pin,
                  i_ext_fault_pin};
      sync2_r <= sync1_r;
    end
  end
  assign ext_s     = sync2_r[4:0];
  assign present_s = sync2_r[5];
  assign answer_s  = sync2_r[6];

  // register writes
  assign clear = i_bus.wr && (i_bus.addr == fault_monitor_pkg::ADDR_CLEAR)
                 && i_bus.wdata[0];
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      set_r     <= fault_monitor_pkg::SET_RESET;
      ans_dly_r <= fault_monitor_pkg::ANS_DLY_RESET;
      noload_r  <= fault_monitor_pkg::NOLOAD_RESET;
    end else if (i_bus.wr) begin
      if (i_bus.addr == fault_monitor_pkg::ADDR_CTRL)
        set_r <= i_bus.wdata[fault_monitor_pkg::SET_W-1:0];
      if (i_bus.addr == fault_monitor_pkg::ADDR_ANS_DLY)
        ans_dly_r <= i_bus.wdata[15:0];
      if (i_bus.addr == fault_monitor_pkg::ADDR_NOLOAD)
        noload_r <= i_bus.wdata[15:0];
    end
  end

  // register reads, data one cycle after strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= '0;
      if (i_bus.rd) begin
        case (i_bus.addr)
          fault_monitor_pkg::ADDR_CTRL:
            o_rdata <= {27'h0000000, set_r};
          fault_monitor_pkg::ADDR_ANS_DLY:
            o_rdata <= {16'h0000, ans_dly_r};
          fault_monitor_pkg::ADDR_NOLOAD:
            o_rdata <= {16'h0000, noload_r};
          fault_monitor_pkg::ADDR_STATUS:
            o_rdata <= {3'h0, flags_r, 12'h000, code_r};
          default:
            o_rdata <= '0;
        endcase
      end
    end
  end

  assign raw[fault_monitor_pkg::F_EXT +: fault_monitor_pkg::NTERM] =
    ext_s;
  assign raw[fault_monitor_pkg::F_DISC] = !present_s &&
    (set_r.run_command_source_sel == fault_monitor_pkg::RUN_SRC_PANEL);

  // host serial link watchdog
  assign host_on = set_r.host_link_timeout_enable &&
    (set_r.host_link_error_action <= fault_monitor_pkg::ACTION_MAX);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      host_cnt_r <= '0;
    end else if (!host_on || i_host_rx_ok) begin
      host_cnt_r <= '0;
    end else if (host_cnt_r < HOST_TIMEOUT_CYC) begin
      host_cnt_r <= host_cnt_r + 32'h00000001;
    end
  end
  assign raw[fault_monitor_pkg::F_HOST] = host_on &&
    (host_cnt_r >= HOST_TIMEOUT_CYC);

  // option link loss after first contact
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      opt_est_r <= 1'b0;
    end else if (i_option_link_up) begin
      opt_est_r <= 1'b1;
    end
  end
  assign raw[fault_monitor_pkg::F_OPT] = opt_est_r && !i_option_link_up;

  // millisecond tick for the contactor delay
  assign ms_tick = (ms_cnt_r >= MS_CYC - 1);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ms_cnt_r <= '0;
    end else if (ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 32'h00000001;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ans_cnt_r <= '0;
    end else if (!i_contactor_close || answer_s) begin
      ans_cnt_r <= '0;
    end else if (ms_tick && ans_cnt_r <= ans_dly_r) begin
      ans_cnt_r <= ans_cnt_r + 16'h0001;
    end
  end
  assign raw[fault_monitor_pkg::F_ANS] = i_contactor_close && !answer_s &&
    (ans_cnt_r > ans_dly_r);

  // current below a quarter of no-load
  assign low_cur = ({i_out_current, 2'h0} < {2'h0, noload_r});
  assign raw[fault_monitor_pkg::F_BRAKE] = i_brake_open && low_cur;
  assign raw[fault_monitor_pkg::F_RUN]   = i_running && low_cur;

  // operator panel link supervision
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      panel_r     <= fault_monitor_pkg::PANEL_WAIT;
      panel_cnt_r <= '0;
    end else begin
      case (panel_r)
        fault_monitor_pkg::PANEL_WAIT: begin
          if (i_panel_rx_ok) begin
            panel_r     <= fault_monitor_pkg::PANEL_UP;
            panel_cnt_r <= '0;
          end else if (panel_cnt_r >= PANEL_START_CYC) begin
            panel_r <= fault_monitor_pkg::PANEL_DEAD;
          end else begin
            panel_cnt_r <= panel_cnt_r + 32'h00000001;
          end
        end
        fault_monitor_pkg::PANEL_UP: begin
          if (i_panel_rx_ok) begin
            panel_cnt_r <= '0;
          end else if (panel_cnt_r < PANEL_LOSS_CYC) begin
            panel_cnt_r <= panel_cnt_r + 32'h00000001;
          end
        end
        fault_monitor_pkg::PANEL_DEAD: begin
          panel_cnt_r <= panel_cnt_r;
        end
        default: begin
          panel_r     <= fault_monitor_pkg::PANEL_WAIT;
          panel_cnt_r <= '0;
        end
      endcase
    end
  end
  assign raw[fault_monitor_pkg::F_PSTART] =
    (panel_r == fault_monitor_pkg::PANEL_DEAD);
  assign raw[fault_monitor_pkg::F_PLOSS] =
    (panel_r == fault_monitor_pkg::PANEL_UP) &&
    (panel_cnt_r >= PANEL_LOSS_CYC);

  // lowest index wins among faults of one cycle
  always_comb begin
    raw_code = 4'h0;
    for (int k = fault_monitor_pkg::NFAULT - 1; k >= 0; k--) begin
      if (raw[k])
        raw_code = 4'(k + 1);
    end
  end

  // sticky flags and first code, a new event beats the clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_r <= '0;
      code_r  <= fault_monitor_pkg::CODE_NONE;
    end else begin
      flags_r <= (clear ? '0 : flags_r) | raw;
      if (clear || code_r == fault_monitor_pkg::CODE_NONE)
        code_r <= raw_code;
    end
  end
  assign o_fault_code   = code_r;
  assign o_fault_active = (code_r != fault_monitor_pkg::CODE_NONE);

  sequence s_code_set;
    (code_r != 4'h0) && !clear;
  endsequence

  a_code_held: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_code_set |=> $stable(code_r))
    else $error("latched fault code changed without clear");
  a_flags_sticky: assert property (@(posedge i_clk)
    disable iff (!i_rst_b)
    !clear |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("fault flag dropped without clear");
  a_ext_terminal: assert property (@(posedge i_clk)
    disable iff (!i_rst_b)
    $rose(ext_s[2]) |=> flags_r[fault_monitor_pkg::F_EXT + 2])
    else $error("terminal fault not flagged");
  a_disc_raise: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!present_s && set_r.run_command_source_sel ==
     fault_monitor_pkg::RUN_SRC_PANEL)
    |=> flags_r[fault_monitor_pkg::F_DISC])
    else $error("panel removal not flagged");
  a_host_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !host_on |=> !raw[fault_monitor_pkg::F_HOST])
    else $error("host fault while watchdog off");
  a_host_bound: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (host_on && !i_host_rx_ok && host_cnt_r == HOST_TIMEOUT_CYC - 1
     && !(i_bus.wr && i_bus.addr == fault_monitor_pkg::ADDR_CTRL))
    |=> raw[fault_monitor_pkg::F_HOST])
    else $error("host timeout missed");
  a_opt_first: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !opt_est_r |-> !raw[fault_monitor_pkg::F_OPT])
    else $error("option fault before first link");
  a_ans_restart: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!i_contactor_close || answer_s) |=> (ans_cnt_r == 16'h0000))
    else $error("contactor delay count not restarted");
  a_low_current: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_running && {i_out_current, 2'h0} < {2'h0, noload_r})
    |=> flags_r[fault_monitor_pkg::F_RUN])
    else $error("running low current not flagged");
  a_brake_current: assert property (@(posedge i_clk)
    disable iff (!i_rst_b)
    (i_brake_open && {i_out_current, 2'h0} < {2'h0, noload_r})
    |=> flags_r[fault_monitor_pkg::F_BRAKE])
    else $error("brake low current not flagged");
  a_panel_start: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (panel_r == fault_monitor_pkg::PANEL_WAIT && !i_panel_rx_ok &&
     panel_cnt_r == PANEL_START_CYC) |=> ##1
    flags_r[fault_monitor_pkg::F_PSTART])
    else $error("panel start timeout missed");
  a_panel_loss: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (panel_r == fault_monitor_pkg::PANEL_UP && i_panel_rx_ok)
    |=> !raw[fault_monitor_pkg::F_PLOSS])
    else $error("panel loss despite traffic");

endmodule

`default_nettype wire

// ---- design/unused.sv ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- tb/fault_partner.sv ----
`timescale 1ns/10ps
`default_nettype none

// operator panel, host master and output contactor stand-in
module fault_partner (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_panel_on,
  input  wire logic        i_host_on,
  input  wire logic        i_close,
  input  wire logic [15:0] i_lag,
  output logic             o_panel_ok,
  output logic             o_host_ok,
  output logic             o_answer
);
  logic [2:0]  tick_r;
  logic [15:0] wait_r;

  // frames every eight cycles, none while a link is silenced
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_r <= 3'h0;
    end else begin
      tick_r <= tick_r + 3'h1;
    end
  end
  assign o_panel_ok = i_panel_on && (tick_r == 3'h0);
  assign o_host_ok  = i_host_on && (tick_r == 3'h4);

  // answer back after a set lag, dropped when the close command goes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_r <= 16'h0000;
    end else if (!i_close) begin
      wait_r <= 16'h0000;
    end else if (wait_r != 16'hFFFF) begin
      wait_r <= wait_r + 16'h0001;
    end
  end
  assign o_answer = i_close && (wait_r >= i_lag);
endmodule

`default_nettype wire

// ---- tb/drive_fault_monitor_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module drive_fault_monitor_test;
  logic clk = 1'b0, rst_b = 1'b0, pres = 1'b1, close = 1'b0;
  logic panel_on = 1'b1, host_on = 1'b1, opt = 1'b0;
  logic brake = 1'b0, run = 1'b0, panel_ok, host_ok, ans, act;
  logic [4:0] pins = 5'h00;
  logic [15:0] cur = 16'h0000, lag = 16'h0002;
  logic [31:0] rdata, d;
  logic [3:0] code;
  fault_monitor_pkg::bus_req_type bus = '0;
  int bad_count = 0, n_compared = 0, exp_code = 0, exp_flags = 0, a;

  always #2 clk = ~clk;

  drive_fault_monitor #(.HOST_TIMEOUT_CYC(50), .PANEL_START_CYC(100),
    .PANEL_LOSS_CYC(50), .MS_CYC(4)) DUT (
    .i_clk(clk), .i_rst_b(rst_b),
    .i_bus(bus), .o_rdata(rdata), .i_ext_fault_pin(pins),
    .i_panel_present_pin(pres), .i_contactor_answer_pin(ans),
    .i_panel_rx_ok(panel_ok), .i_host_rx_ok(host_ok),
    .i_option_link_up(opt), .i_contactor_close(close),
    .i_brake_open(brake), .i_running(run), .i_out_current(cur),
    .o_fault_code(code), .o_fault_active(act));

  fault_partner partner (.i_clk(clk), .i_rst_b(rst_b),
    .i_panel_on(panel_on), .i_host_on(host_on), .i_close(close),
    .i_lag(lag), .o_panel_ok(panel_ok), .o_host_ok(host_ok),
    .o_answer(ans));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk) bus <= '{addr: ad, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge clk) bus <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // model: first code latched, later ones only add flags
  task automatic raise(input int idx);
    if (exp_code == 0) exp_code = idx + 1;
    exp_flags |= 1 << idx;
  endtask

  task automatic status;
    rd(fault_monitor_pkg::ADDR_STATUS, d);
    chk(d, (exp_flags << 16) | exp_code);
    chk({27'h0, act, code}, {27'h0, exp_code != 0, exp_code[3:0]});
    @(posedge clk);
  endtask

  task automatic clear;
    wr(fault_monitor_pkg::ADDR_CLEAR, 32'h1);
    exp_code = 0;
    exp_flags = 0;
    repeat (2) @(posedge clk);
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude;
  end

  initial begin
    a = $urandom(78);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(fault_monitor_pkg::ADDR_CTRL, d);
    chk(d, 32'h0);
    rd(fault_monitor_pkg::ADDR_ANS_DLY, d);
    chk(d, 32'h64);
    rd(fault_monitor_pkg::ADDR_NOLOAD, d);
    chk(d, 32'h0);
    rd(8'h20, d);
    chk(d, 32'h0);
    @(posedge clk);
    for (int t = 0; t < 5; t++) begin
      pins <= 5'h01 << t;
      repeat (5) @(posedge clk);
      raise(t);
      status;
      pins[(t + 1) % 5] <= 1'b1;
      repeat (5) @(posedge clk);
      raise((t + 1) % 5);
      status;
      pins <= 5'h00;
      repeat (4) @(posedge clk);
      clear;
      status;
    end
    pres <= 1'b0;
    repeat (5) @(posedge clk);
    raise(fault_monitor_pkg::F_DISC);
    status;
    pres <= 1'b1;
    wr(fault_monitor_pkg::ADDR_CTRL, 32'h1);
    clear;
    pres <= 1'b0;
    repeat (6) @(posedge clk);
    status;
    pres <= 1'b1;
    a = $urandom % 3;
    wr(fault_monitor_pkg::ADDR_CTRL, 32'h11 | (a << 2));
    host_on <= 1'b0;
    repeat (70) @(posedge clk);
    raise(fault_monitor_pkg::F_HOST);
    status;
    host_on <= 1'b1;
    repeat (10) @(posedge clk);
    clear;
    wr(fault_monitor_pkg::ADDR_CTRL, 32'h1D);
    host_on <= 1'b0;
    repeat (70) @(posedge clk);
    status;
    host_on <= 1'b1;
    wr(fault_monitor_pkg::ADDR_CTRL, 32'h1);
    status;
    opt <= 1'b1;
    repeat (3) @(posedge clk);
    opt <= 1'b0;
    repeat (3) @(posedge clk);
    raise(fault_monitor_pkg::F_OPT);
    status;
    opt <= 1'b1;
    clear;
    wr(fault_monitor_pkg::ADDR_ANS_DLY, 32'h3);
    close <= 1'b1;
    repeat (40) @(posedge clk);
    status;
    close <= 1'b0;
    lag <= 16'h03E8;
    @(posedge clk) close <= 1'b1;
    repeat (40) @(posedge clk);
    raise(fault_monitor_pkg::F_ANS);
    status;
    close <= 1'b0;
    clear;
    wr(fault_monitor_pkg::ADDR_NOLOAD, 32'h00000064);
    cur <= 16'h0019;
    brake <= 1'b1;
    run <= 1'b1;
    repeat (4) @(posedge clk);
    status;
    cur <= 16'($urandom % 25);
    run <= 1'b0;
    repeat (3) @(posedge clk);
    raise(fault_monitor_pkg::F_BRAKE);
    status;
    brake <= 1'b0;
    clear;
    run <= 1'b1;
    repeat (3) @(posedge clk);
    raise(fault_monitor_pkg::F_RUN);
    status;
    run <= 1'b0;
    clear;
    panel_on <= 1'b0;
    repeat (70) @(posedge clk);
    raise(fault_monitor_pkg::F_PLOSS);
    status;
    rst_b <= 1'b0;
    exp_code = 0;
    exp_flags = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (120) @(posedge clk);
    raise(fault_monitor_pkg::F_PSTART);
    status;
    clear;
    raise(fault_monitor_pkg::F_PSTART);
    status;
    conclude;
  end
endmodule

`default_nettype wire
